// [common/imc_pkg.sv]
// Overview of operation
// - three half-band stages per I and Q channel
// - ctrl bits 7:6 at 00 bypass interpolation
// - code 01 interpolates two, sequence +1,-1
// - code 10 interpolates four, sequence 0,1,0,-1
// - code 11 interpolates eight, printed eight-term sequence
// - ctrl bits 5:4 select modulation rate or off
// - interpolation filters sit before the modulator
// - quarter and eighth rate halve spectral images
// - ctrl bit 3 enables zero stuffing
// - zero stuffing doubles rate, inserts midscale samples
// - midscale insertion follows the modulator output
package imc_pkg;
    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int DW = 16;
    localparam int CW = 17;
    localparam int ACC_W = 40;
    localparam int NSTAGE = 3;
    localparam int NCH = 2;
    localparam int HIST = 4;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_IDX = 8'h01;
    localparam logic [7:0] CTRL_ADDR = {CTRL_IDX[5:0], 2'b00};
    localparam logic [7:0] STAT_IDX = 8'h02;
    localparam logic [7:0] STAT_ADDR = {STAT_IDX[5:0], 2'b00};
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_RW_MASK = 8'hF8;
    localparam int INTERP_LO = 6;
    localparam int MOD_LO = 4;
    localparam int ZS_BIT = 3;
    localparam int STAT_UNDER_BIT = 0;
    localparam int STAT_IDX_LO = 1;

    typedef enum logic [1:0] {
        IMC_MOD_OFF,
        IMC_MOD_HALF,
        IMC_MOD_QUARTER,
        IMC_MOD_EIGHTH
    } imc_mod_e;

    // ------------------------------------------------------------------
    // arithmetic constants
    // ------------------------------------------------------------------
    localparam logic signed [CW-1:0] COEF_ZERO = 17'h00000;
    localparam logic signed [CW-1:0] COEF_ONE = 17'h08000;
    localparam logic signed [CW-1:0] COEF_NONE = 17'h18000;
    localparam logic signed [CW-1:0] COEF_P707 = 17'h05A7F;
    localparam logic signed [CW-1:0] COEF_N707 = 17'h1A581;
    // last term kept as printed; a true sine would end negative
    localparam logic signed [CW-1:0] COEF_LAST = COEF_P707;
    localparam logic signed [CW-1:0] SEQ8 [8] = '{COEF_ZERO, COEF_P707, COEF_ONE,
        COEF_P707, COEF_ZERO, COEF_N707, COEF_NONE, COEF_LAST};
    localparam int COEF_FRAC = 15;
    localparam logic signed [ACC_W-1:0] HB_CENTER = 40'sh00_0000_0009;
    localparam int HB_SHIFT = 4;
    localparam logic signed [ACC_W-1:0] SAT_MAX = 40'sh00_0000_7FFF;
    localparam logic signed [ACC_W-1:0] SAT_MIN = 40'shFF_FFFF_8000;
    localparam logic [DW-1:0] DAC_MIDSCALE = 16'h8000;
    localparam logic [2:0] LOW_MASK [4] = '{3'h0, 3'h1, 3'h3, 3'h7};

    function automatic logic signed [DW-1:0] imc_sat(input logic signed [ACC_W-1:0] v);
        logic signed [DW-1:0] r;
        r = v[DW-1:0];
        if (v > SAT_MAX) begin
            r = SAT_MAX[DW-1:0];
        end else if (v < SAT_MIN) begin
            r = SAT_MIN[DW-1:0];
        end
        return r;
    endfunction
endpackage

// [rtl/imc_halfband.sv]
module imc_halfband
    import imc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tick,
    input wire logic phase,
    input wire logic signed [DW-1:0] din,
    output logic signed [DW-1:0] dout
);
    // ------------------------------------------------------------------
    // history and output
    // ------------------------------------------------------------------
    logic signed [DW-1:0] hist_ff [HIST];
    logic signed [DW-1:0] nxt_hist [HIST];
    logic signed [DW-1:0] dout_ff;
    logic signed [DW-1:0] nxt_dout;
    logic signed [ACC_W-1:0] inner;
    logic signed [ACC_W-1:0] outer;
    logic signed [ACC_W-1:0] acc;

    always_comb begin
        nxt_hist = hist_ff;
        nxt_dout = dout_ff;
        inner = ACC_W'(hist_ff[1]) + ACC_W'(hist_ff[2]);
        outer = ACC_W'(hist_ff[0]) + ACC_W'(hist_ff[3]);
        acc = (inner * HB_CENTER - outer) >>> HB_SHIFT;
        if (tick) begin
            if (!phase) begin
                // even phase: take a sample, emit the centre tap
                nxt_hist[0] = din;
                for (int k = 1; k < HIST; k++) begin
                    nxt_hist[k] = hist_ff[k-1];
                end
                nxt_dout = hist_ff[1];
            end else begin
                // odd phase: midpoint between the two centre samples
                nxt_dout = imc_sat(acc);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int k = 0; k < HIST; k++) begin
                hist_ff[k] <= '0;
            end
            dout_ff <= '0;
        end else begin
            hist_ff <= nxt_hist;
            dout_ff <= nxt_dout;
        end
    end

    assign dout = dout_ff;
endmodule // imc_halfband

// [rtl/imc_modulator.sv]
module imc_modulator
    import imc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tick,
    input wire logic [1:0] mod_sel,
    input wire logic signed [DW-1:0] din,
    output logic signed [DW-1:0] dout,
    output logic [2:0] idx
);
    // ------------------------------------------------------------------
    // coefficient walk and product
    // ------------------------------------------------------------------
    logic [2:0] idx_ff;
    logic [2:0] nxt_idx;
    logic signed [DW-1:0] dout_ff;
    logic signed [DW-1:0] nxt_dout;
    logic signed [CW-1:0] coef;
    logic signed [ACC_W-1:0] prod;
    imc_mod_e mode;

    always_comb begin
        mode = imc_mod_e'(mod_sel);
        unique case (mode)
            IMC_MOD_OFF: coef = COEF_ONE;
            IMC_MOD_HALF: coef = idx_ff[0] ? COEF_NONE : COEF_ONE;
            IMC_MOD_QUARTER: begin
                coef = idx_ff[0] ? (idx_ff[1] ? COEF_NONE : COEF_ONE) : COEF_ZERO;
            end
            IMC_MOD_EIGHTH: coef = SEQ8[idx_ff];
        endcase
        // no gain makeup: sparse carriers leave images at half size
        prod = (ACC_W'(din) * ACC_W'(coef)) >>> COEF_FRAC;
        nxt_idx = idx_ff;
        nxt_dout = dout_ff;
        if (tick) begin
            // three-bit wrap serves all periods since 2 and 4 divide 8
            nxt_idx = idx_ff + 3'h1;
            nxt_dout = (mode == IMC_MOD_OFF) ? din : imc_sat(prod);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            idx_ff <= '0;
            dout_ff <= '0;
        end else begin
            idx_ff <= nxt_idx;
            dout_ff <= nxt_dout;
        end
    end

    assign dout = dout_ff;
    assign idx = idx_ff;
endmodule // imc_modulator

// [rtl/imc_top.sv]
module imc_top
    import imc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic in_valid,
    input wire logic signed [DW-1:0] in_i,
    input wire logic signed [DW-1:0] in_q,
    output logic in_ready,
    output logic [DW-1:0] dac_i,
    output logic [DW-1:0] dac_q
);
    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic under_ff;
    logic nxt_under;
    logic ack_ff;
    logic nxt_ack;
    logic [31:0] dat_ff;
    logic [31:0] nxt_dat;
    logic bus_req;
    logic [2:0] mod_idx [NCH];
    logic take;
    logic hold_full_ff;

    always_comb begin
        bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
        nxt_ctrl = ctrl_ff;
        nxt_ack = bus_req;
        nxt_dat = '0;
        nxt_under = under_ff;
        if (bus_req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == CTRL_ADDR) begin
                nxt_ctrl = wb_dat_i[7:0] & CTRL_RW_MASK;
            end else if (wb_adr_i == STAT_ADDR && wb_dat_i[STAT_UNDER_BIT]) begin
                nxt_under = 1'b0;
            end
        end
        // a starved slot in the clearing cycle still registers
        if (take && !hold_full_ff) begin
            nxt_under = 1'b1;
        end
        if (bus_req && !wb_we_i) begin
            if (wb_adr_i == CTRL_ADDR) begin
                nxt_dat[7:0] = ctrl_ff;
            end else if (wb_adr_i == STAT_ADDR) begin
                nxt_dat[STAT_UNDER_BIT] = under_ff;
                nxt_dat[STAT_IDX_LO +: 3] = mod_idx[0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_ff <= CTRL_RESET;
            under_ff <= 1'b0;
            ack_ff <= 1'b0;
            dat_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            under_ff <= nxt_under;
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
        end
    end

    // ------------------------------------------------------------------
    // rate scheduler
    // ------------------------------------------------------------------
    logic [1:0] interp;
    logic [1:0] mod_sel;
    logic zs_en;
    logic zs_ph_ff;
    logic nxt_zs_ph;
    logic [2:0] div_ff;
    logic [2:0] nxt_div;
    logic path_tick;
    logic [NSTAGE-1:0] stage_tick;
    logic [NSTAGE-1:0] stage_phase;
    logic take_nxt;
    int sh;

    always_comb begin
        interp = ctrl_ff[INTERP_LO +: 2];
        mod_sel = ctrl_ff[MOD_LO +: 2];
        zs_en = ctrl_ff[ZS_BIT];
        // with stuffing the path runs at half the converter rate
        path_tick = ~zs_en | ~zs_ph_ff;
        nxt_zs_ph = zs_en & ~zs_ph_ff;
        nxt_div = path_tick ? div_ff + 3'h1 : div_ff;
        // input slot once per 2^interp path samples; 00 means every one
        take = path_tick & ((div_ff & LOW_MASK[interp]) == 3'h0);
        // look one edge ahead so a 1x stream needs no bubble
        take_nxt = (~nxt_ctrl[ZS_BIT] | ~nxt_zs_ph)
            & ((nxt_div & LOW_MASK[nxt_ctrl[INTERP_LO +: 2]]) == 3'h0);
        stage_tick = '0;
        stage_phase = '0;
        sh = 0;
        for (int s = 0; s < NSTAGE; s++) begin
            if (s < int'(interp)) begin
                sh = int'(interp) - 1 - s;
                stage_tick[s] = path_tick & ((div_ff & LOW_MASK[sh]) == 3'h0);
                stage_phase[s] = div_ff[sh];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            zs_ph_ff <= 1'b0;
            div_ff <= '0;
        end else begin
            zs_ph_ff <= nxt_zs_ph;
            div_ff <= nxt_div;
        end
    end

    // ------------------------------------------------------------------
    // input hold, one sample per channel
    // ------------------------------------------------------------------
    logic signed [DW-1:0] hold_ff [NCH];
    logic signed [DW-1:0] nxt_hold [NCH];
    logic nxt_hold_full;
    logic ready_ff;
    logic signed [DW-1:0] feed [NCH];

    always_comb begin
        nxt_hold = hold_ff;
        nxt_hold_full = hold_full_ff;
        if (take) begin
            nxt_hold_full = 1'b0;
        end
        if (in_valid && ready_ff) begin
            nxt_hold[0] = in_i;
            nxt_hold[1] = in_q;
            nxt_hold_full = 1'b1;
        end
        // starved slots feed zero rather than repeating old data
        for (int c = 0; c < NCH; c++) begin
            feed[c] = hold_full_ff ? hold_ff[c] : '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int c = 0; c < NCH; c++) begin
                hold_ff[c] <= '0;
            end
            hold_full_ff <= 1'b0;
            ready_ff <= 1'b0;
        end else begin
            hold_ff <= nxt_hold;
            hold_full_ff <= nxt_hold_full;
            ready_ff <= ~nxt_hold_full | take_nxt;
        end
    end

    // ------------------------------------------------------------------
    // interpolators and modulators
    // ------------------------------------------------------------------
    logic signed [DW-1:0] stage_out [NCH][NSTAGE];
    logic signed [DW-1:0] mod_src [NCH];
    logic signed [DW-1:0] mod_out [NCH];

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        for (genvar s = 0; s < NSTAGE; s++) begin : g_stage
            logic signed [DW-1:0] stage_in;
            if (s == 0) begin : g_first
                assign stage_in = feed[c];
            end else begin : g_next
                assign stage_in = stage_out[c][s-1];
            end
            imc_halfband u_hb (
                .clk_sys(clk_sys),
                .rst(rst),
                .tick(stage_tick[s]),
                .phase(stage_phase[s]),
                .din(stage_in),
                .dout(stage_out[c][s])
            );
        end
        // modulator sees the filtered stream, or the unfiltered feed when interp is 00
        assign mod_src[c] = (interp == 2'h0) ? feed[c] : stage_out[c][interp - 2'h1];
        imc_modulator u_mod (
            .clk_sys(clk_sys),
            .rst(rst),
            .tick(path_tick),
            .mod_sel(mod_sel),
            .din(mod_src[c]),
            .dout(mod_out[c]),
            .idx(mod_idx[c])
        );
    end

    // ------------------------------------------------------------------
    // zero stuffing and converter codes
    // ------------------------------------------------------------------
    logic [DW-1:0] dac_ff [NCH];
    logic [DW-1:0] nxt_dac [NCH];

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            // stuffing slot sits after the modulator, at the converter output
            if (zs_en && !zs_ph_ff) begin
                nxt_dac[c] = DAC_MIDSCALE;
            end else begin
                nxt_dac[c] = {~mod_out[c][DW-1], mod_out[c][DW-2:0]};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int c = 0; c < NCH; c++) begin
                dac_ff[c] <= DAC_MIDSCALE;
            end
        end else begin
            dac_ff <= nxt_dac;
        end
    end

    assign wb_dat_o = dat_ff;
    assign wb_ack_o = ack_ff;
    assign in_ready = ready_ff;
    assign dac_i = dac_ff[0];
    assign dac_q = dac_ff[1];
endmodule // imc_top

// [verif/imc_top_asserts.sv]
module imc_top_chk
    import imc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic [DW-1:0] dac_i,
    input wire logic [DW-1:0] dac_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [7:0] ctrl_ff, nxt_ctrl, calm_ff, nxt_calm;
    logic [4:0] gap_ff, nxt_gap, per;
    logic calm, acc, plain;
    // calm waits out filter fill after any mode change or source gap
    always_comb begin
        acc = in_valid && in_ready;
        per = 5'h01 << ({1'b0, ctrl_ff[7:6]} + {2'h0, ctrl_ff[ZS_BIT]});
        calm = calm_ff >= 8'hC8;
        plain = calm && !ctrl_ff[ZS_BIT];
        nxt_ctrl = ctrl_ff;
        nxt_calm = calm_ff + {7'h00, calm_ff != 8'hFF};
        nxt_gap = acc ? 5'h01 : gap_ff + {4'h0, gap_ff != 5'h1F};
        if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                && wb_adr_i == CTRL_ADDR) begin
            nxt_ctrl = wb_dat_i[7:0] & CTRL_RW_MASK;
        end
        if (nxt_ctrl != ctrl_ff || !in_valid) begin
            nxt_calm = 8'h00;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_ff <= CTRL_RESET;
            calm_ff <= 8'h00;
            gap_ff <= 5'h1F;
        end else begin
            ctrl_ff <= nxt_ctrl;
            calm_ff <= nxt_calm;
            gap_ff <= nxt_gap;
        end
    end
    property p_ack_once;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("bus ack not one pulse");
    property p_ready_drop;
        calm && acc && per != 5'h01 |=> !in_ready;
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("hold not closed");
    property p_rate;
        calm && acc |-> gap_ff == per;
    endproperty
    a_rate: assert property (p_rate) else $error("input slot spacing wrong");
    property p_off_pass;
        plain && ctrl_ff[5:4] == 2'h0 |-> $stable(dac_i) && $stable(dac_q);
    endproperty
    a_off_pass: assert property (p_off_pass) else $error("steady input not passed");
    property p_half_flip;
        plain && ctrl_ff[5:4] == 2'h1 |->
            ((dac_i ^ 16'h8000) + ($past(dac_i) ^ 16'h8000)) == 16'h0000;
    endproperty
    a_half_flip: assert property (p_half_flip) else $error("half rate sign");
    property p_quart_zero;
        plain && ctrl_ff[5:4] == 2'h2 && $past(dac_i) != 16'h8000 |-> dac_i == 16'h8000;
    endproperty
    a_quart_zero: assert property (p_quart_zero) else $error("quarter zero term");
    property p_quart_neg;
        plain && ctrl_ff[5:4] == 2'h2 |->
            ((dac_i ^ 16'h8000) + ($past(dac_i, 2) ^ 16'h8000)) == 16'h0000;
    endproperty
    a_quart_neg: assert property (p_quart_neg) else $error("quarter sign");
    property p_eighth_wrap;
        plain && ctrl_ff[5:4] == 2'h3 |-> dac_i == $past(dac_i, 8) && dac_q == $past(dac_q, 8);
    endproperty
    a_eighth_wrap: assert property (p_eighth_wrap) else $error("eighth not cyclic");
    property p_zs_mid;
        calm && ctrl_ff[ZS_BIT] && $past(dac_i) != 16'h8000 |-> dac_i == 16'h8000;
    endproperty
    a_zs_mid: assert property (p_zs_mid) else $error("midscale not stuffed");
endmodule // imc_top_chk

bind imc_top imc_top_chk u_chk (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .in_valid(in_valid), .in_ready(in_ready),
    .dac_i(dac_i), .dac_q(dac_q)
);

// [verif/imc_src_model.sv]
module imc_src_model
    import imc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic slow,
    input wire logic signed [DW-1:0] dc_i,
    input wire logic signed [DW-1:0] dc_q,
    input wire logic in_ready,
    output logic in_valid,
    output logic signed [DW-1:0] in_i,
    output logic signed [DW-1:0] in_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] idle_ff;
    // released lines toggle so a stale sample cannot pass for data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            in_valid <= 1'b0;
            idle_ff <= 2'h0;
            in_i <= ~dc_i;
            in_q <= ~dc_q;
        end else if (in_valid && in_ready && slow) begin
            in_valid <= 1'b0;
            idle_ff <= 2'h3;
            in_i <= ~in_i;
            in_q <= ~in_q;
        end else if (idle_ff != 2'h0) begin
            idle_ff <= idle_ff - 2'h1;
            in_i <= ~in_i;
            in_q <= ~in_q;
        end else if (!in_valid || in_ready) begin
            in_valid <= 1'b1;
            in_i <= dc_i;
            in_q <= dc_q;
        end
    end
endmodule // imc_src_model

// [verif/imc_top_tb_top.sv]
module imc_top_tb_top
    import imc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic signed [CW-1:0] E8 [8] = '{COEF_ZERO, COEF_P707, COEF_ONE, COEF_P707,
        COEF_ZERO, COEF_N707, COEF_NONE, COEF_P707};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, slow = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
    logic wb_ack_o, in_valid, in_ready;
    logic signed [DW-1:0] in_i, in_q, dc_i = 16'h0400, dc_q = 16'h0400;
    logic [DW-1:0] dac_i, dac_q;
    logic [DW-1:0] si [16], sq [16];
    logic [15:0] seed = 16'h0058;
    int bad_count = 0, checks = 0, cyc_cnt = 0;

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    imc_top dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .in_valid(in_valid), .in_i(in_i),
        .in_q(in_q), .in_ready(in_ready), .dac_i(dac_i), .dac_q(dac_q));
    imc_src_model u_src (.clk_sys(clk_sys), .rst(rst), .slow(slow), .dc_i(dc_i),
        .dc_q(dc_q), .in_ready(in_ready), .in_valid(in_valid), .in_i(in_i), .in_q(in_q));

    // --------
    // helpers
    // --------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // expected sample, offset binary; stuffed slots are odd positions
    function automatic logic [15:0] ev(int x, int m, int z, int p);
        logic signed [CW-1:0] c;
        c = COEF_ZERO;
        if (!(z != 0 && p % 2 != 0)) begin
            p = p >> z;
            case (m)
                0: c = COEF_ONE;
                1: c = (p % 2 != 0) ? COEF_NONE : COEF_ONE;
                2: c = (p % 2 == 0) ? COEF_ZERO : (p == 1) ? COEF_ONE : COEF_NONE;
                default: c = E8[p];
            endcase
        end
        return 16'((x * c) >>> COEF_FRAC) ^ 16'h8000;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // tol allows one lsb for the rounded 0.707 terms
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input bit tol);
        checks++;
        if (!(seen === exp || (tol && ((seen - exp) === 32'h1 || (exp - seen) === 32'h1))))
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        if (n >= 100) begin
            bad_count++;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic gap(output int g);
        g = 0;
        do begin
            @(posedge clk_sys);
            g++;
        end while (!(in_valid === 1'b1 && in_ready === 1'b1) && g < 100);
        if (g >= 100) begin
            bad_count++;
        end
    endtask

    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    // --------
    // scenarios
    // --------
    initial begin
        int it, md, zs, x, y, g, k, a, len;
        logic [7:0] v;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        wb(1'b0, CTRL_ADDR, 32'h0, 4'hF, r);
        chk(r, {24'h0, CTRL_RESET}, 1'b0);
        wb(1'b0, 8'h10, 32'h0, 4'hF, r);
        chk(r, 32'h0, 1'b0);
        wb(1'b1, CTRL_ADDR, 32'hFF, 4'hE, r);
        wb(1'b0, CTRL_ADDR, 32'h0, 4'hF, r);
        chk(r, {24'h0, CTRL_RESET}, 1'b0);
        for (int c = 0; c < 20; c++) begin
            it = c < 16 ? c / 4 : c - 16;
            md = c < 16 ? c % 4 : c - 16;
            zs = c / 16;
            v = {it[1:0], md[1:0], zs[0], 3'h7};
            wb(1'b1, CTRL_ADDR, {24'h0, v}, 4'hF, r);
            seed = lfsr(seed);
            x = 1024 + seed[11:0];
            seed = lfsr(seed);
            y = 1024 + seed[11:0];
            dc_i <= 16'(x);
            dc_q <= 16'(y);
            wb(1'b0, CTRL_ADDR, 32'h0, 4'hF, r);
            chk(r, {24'h0, v & CTRL_RW_MASK}, 1'b0);
            repeat (24) gap(g);
            gap(g);
            chk(g, 1 << (it + zs), 1'b0);
            for (int j = 0; j < 16; j++) begin
                @(posedge clk_sys);
                si[j] = dac_i;
                sq[j] = dac_q;
            end
            // align on the unique minus-one term (plus-one when unmodulated)
            len = (1 << md) << zs;
            a = (md == 3 ? 6 : md == 2 ? 3 : md) << zs;
            k = 0;
            for (int j = 15; j >= 0; j--) begin
                if (si[j] === ev(x, md, zs, a)) begin
                    k = j;
                end
            end
            for (int j = 0; j < 16; j++) begin
                chk(si[j], ev(x, md, zs, (a + j - k + 16) % len), 1'b1);
                chk(sq[j], ev(y, md, zs, (a + j - k + 16) % len), 1'b1);
            end
        end
        // starved source: a slot finds the hold empty
        slow <= 1'b1;
        wb(1'b1, CTRL_ADDR, 32'h40, 4'hF, r);
        repeat (8) gap(g);
        wb(1'b0, STAT_ADDR, 32'h0, 4'hF, r);
        chk(r[STAT_UNDER_BIT], 1'b1, 1'b0);
        slow <= 1'b0;
        repeat (8) gap(g);
        wb(1'b1, STAT_ADDR, 32'h1, 4'hF, r);
        wb(1'b0, STAT_ADDR, 32'h0, 4'hF, r);
        chk(r[STAT_UNDER_BIT], 1'b0, 1'b0);
        tally_and_finish();
    end
endmodule // imc_top_tb_top
